// ==== pkg/pfp_cfg.svh ====
// Summary of operation
// - Modes 4, 8, 11 use bits 4:0 as the partner port index.
// - Bits 7:5 are exponent N; averaging count is two to the N, 1 to 128.
// - ADC modes only: average that many conversions, then write one result.
// - Range field picks input range in input modes, output range in output modes.
// - Code 001 is 0 to +10 V, 010 is -5 to +5 V, 011 is -10 to 0 V.
// - DAC related modes are 1, 3, 4, 5, 6 and 10.
`ifndef PFP_CFG_SVH
`define PFP_CFG_SVH

// =====================================================================
// Sizes
`define PFP_NPORT        20
`define PFP_REG_W        12
`define PFP_ADDR_W       5
`define PFP_MODE_W       4
`define PFP_ADC_W        12
`define PFP_MAX_PORT     5'h13

// =====================================================================
// Field layout and reset value
`define PFP_PARTNER_MSB  4
`define PFP_PARTNER_LSB  0
`define PFP_EXP_MSB      7
`define PFP_EXP_LSB      5
`define PFP_RANGE_MSB    10
`define PFP_RANGE_LSB    8
`define PFP_CFG_RST      12'h000

// =====================================================================
// Mode classes, one bit per mode number
`define PFP_DAC_MODES    16'h047a
`define PFP_ADC_MODES    16'h0780
`define PFP_PAIR_MODES   16'h0910

// =====================================================================
// Range codes
`define PFP_RC_NONE      3'h0
`define PFP_RC_0_P10     3'h1
`define PFP_RC_M5_P5     3'h2
`define PFP_RC_M10_0     3'h3

`endif

// ==== pkg/pfp_pkg.sv ====
`include "pfp_cfg.svh"

package pfp_pkg;

  typedef enum logic [2:0] {
    PFP_RNG_OFF,
    PFP_RNG_0_P10,
    PFP_RNG_M5_P5,
    PFP_RNG_M10_0,
    PFP_RNG_OTHER
  } pfp_range_t;

  typedef logic [`PFP_REG_W-1:0] pfp_cfg_t;

  function automatic logic [4:0] pfp_partner(input pfp_cfg_t c);
    pfp_partner = c[`PFP_PARTNER_MSB:`PFP_PARTNER_LSB];
  endfunction : pfp_partner

  function automatic logic [2:0] pfp_exp(input pfp_cfg_t c);
    pfp_exp = c[`PFP_EXP_MSB:`PFP_EXP_LSB];
  endfunction : pfp_exp

  function automatic logic [2:0] pfp_range(input pfp_cfg_t c);
    pfp_range = c[`PFP_RANGE_MSB:`PFP_RANGE_LSB];
  endfunction : pfp_range

  function automatic logic pfp_in_class(input logic [15:0] mask,
                                        input logic [`PFP_MODE_W-1:0] mode);
    pfp_in_class = mask[mode];
  endfunction : pfp_in_class

endpackage : pfp_pkg

// ==== rtl/pfp_rng.sv ====
`timescale 1ns/1ps
`include "pfp_cfg.svh"

module pfp_rng
  import pfp_pkg::*;
(
  input  wire logic [2:0] range_code,
  input  wire logic       is_input,
  input  wire logic       is_output,
  input  wire logic       is_analog,
  output pfp_range_t      in_range,
  output pfp_range_t      out_range,
  output logic            code_bad
);

  pfp_range_t dec_range;

  // =====================================================================
  // Code decode, shared by inputs and outputs
  always_comb
  begin
    case (range_code)
      `PFP_RC_NONE:  dec_range = PFP_RNG_OFF;
      `PFP_RC_0_P10: dec_range = PFP_RNG_0_P10;
      `PFP_RC_M5_P5: dec_range = PFP_RNG_M5_P5;
      `PFP_RC_M10_0: dec_range = PFP_RNG_M10_0;
      default:       dec_range = PFP_RNG_OTHER;
    endcase
  end

  always_comb
  begin
    in_range  = is_input  ? dec_range : PFP_RNG_OFF;
    out_range = is_output ? dec_range : PFP_RNG_OFF;
    // Flag only; the value is still stored as written
    code_bad  = is_analog && (range_code == `PFP_RC_NONE);
  end

endmodule : pfp_rng

// ==== rtl/pfp_avg.sv ====
`timescale 1ns/1ps
`include "pfp_cfg.svh"

module pfp_avg
  import pfp_pkg::*;
#(
  parameter int NPORT = `PFP_NPORT,
  parameter int DW    = `PFP_ADC_W,
  parameter int EXPW  = 3
)
(
  input  wire logic             clk_sys,
  input  wire logic             rst_b,
  input  wire logic [NPORT-1:0] adc_en,
  input  wire logic             clr_valid,
  input  wire logic [4:0]       clr_port,
  input  wire logic             smp_valid,
  input  wire logic [4:0]       smp_port,
  input  wire logic [DW-1:0]    smp_data,
  input  wire logic [EXPW-1:0]  smp_exp,
  output logic                  res_valid,
  output logic [4:0]            res_port,
  output logic [DW-1:0]         res_data
);

  localparam int ACCW = DW + (2**EXPW) - 1;
  localparam int CNTW = 2**EXPW;

  // =====================================================================
  // Elaboration check
  // Port index is five bits wide; a zero-width exponent makes no sense
  if ((NPORT < 1) || (NPORT > 32) || (EXPW < 1))
  begin : g_bad_param
    $error("pfp_avg: NPORT or EXPW out of range");
  end

  logic [ACCW-1:0] acc_ff [NPORT];
  logic [ACCW-1:0] nxt_acc [NPORT];
  logic [CNTW-1:0] cnt_ff [NPORT];
  logic [CNTW-1:0] nxt_cnt [NPORT];
  logic            res_valid_ff;
  logic            nxt_res_valid;
  logic [4:0]      res_port_ff;
  logic [4:0]      nxt_res_port;
  logic [DW-1:0]   res_data_ff;
  logic [DW-1:0]   nxt_res_data;

  // =====================================================================
  // Accumulate and dump
  always_comb
  begin
    logic [ACCW-1:0] sum;
    logic [CNTW-1:0] tgt;
    sum = '0;
    tgt = '0;
    nxt_res_valid = 1'b0;
    nxt_res_port  = res_port_ff;
    nxt_res_data  = res_data_ff;
    for (int p = 0; p < NPORT; p++)
    begin
      nxt_acc[p] = adc_en[p] ? acc_ff[p] : '0;
      nxt_cnt[p] = adc_en[p] ? cnt_ff[p] : '0;
    end
    // A rewrite restarts the run, so no result mixes two settings
    if (clr_valid && (32'(clr_port) < NPORT))
    begin
      nxt_acc[clr_port] = '0;
      nxt_cnt[clr_port] = '0;
    end
    if (smp_valid && (32'(smp_port) < NPORT) && adc_en[smp_port]
        && !(clr_valid && (clr_port == smp_port)))
    begin
      sum = acc_ff[smp_port] + ACCW'(smp_data);
      tgt = CNTW'(1) << smp_exp;
      if (CNTW'(cnt_ff[smp_port] + 1'b1) == tgt)
      begin
        nxt_res_valid          = 1'b1;
        nxt_res_port           = smp_port;
        nxt_res_data           = DW'(sum >> smp_exp);
        nxt_acc[smp_port]      = '0;
        nxt_cnt[smp_port]      = '0;
      end
      else
      begin
        nxt_acc[smp_port] = sum;
        nxt_cnt[smp_port] = CNTW'(cnt_ff[smp_port] + 1'b1);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int p = 0; p < NPORT; p++)
      begin
        acc_ff[p] <= '0;
        cnt_ff[p] <= '0;
      end
      res_valid_ff <= 1'b0;
      res_port_ff  <= '0;
      res_data_ff  <= '0;
    end
    else
    begin
      acc_ff       <= nxt_acc;
      cnt_ff       <= nxt_cnt;
      res_valid_ff <= nxt_res_valid;
      res_port_ff  <= nxt_res_port;
      res_data_ff  <= nxt_res_data;
    end
  end

  assign res_valid = res_valid_ff;
  assign res_port  = res_port_ff;
  assign res_data  = res_data_ff;

endmodule : pfp_avg

// ==== rtl/pfp_top.sv ====
`timescale 1ns/1ps
`include "pfp_cfg.svh"

module pfp_top
  import pfp_pkg::*;
#(
  parameter int NPORT = `PFP_NPORT
)
(
  input  wire logic                            clk_sys,
  input  wire logic                            rst_b,
  input  wire logic                            reg_wr_en,
  input  wire logic                            reg_rd_en,
  input  wire logic [`PFP_ADDR_W-1:0]          reg_addr,
  input  wire logic [`PFP_REG_W-1:0]           reg_wdata,
  output logic      [`PFP_REG_W-1:0]           reg_rdata,
  output logic                                 reg_rvalid,
  input  wire logic [NPORT*`PFP_MODE_W-1:0]    port_mode_flat,
  output logic      [NPORT-1:0]                partner_valid,
  output logic      [NPORT*5-1:0]              partner_idx_flat,
  output logic      [NPORT*8-1:0]              avg_count_flat,
  output logic      [NPORT*3-1:0]              in_range_flat,
  output logic      [NPORT*3-1:0]              out_range_flat,
  output logic      [NPORT-1:0]                range_err,
  input  wire logic                            adc_smp_valid,
  input  wire logic [4:0]                      adc_smp_port,
  input  wire logic [`PFP_ADC_W-1:0]           adc_smp_data,
  output logic                                 adc_res_valid,
  output logic      [4:0]                      adc_res_port,
  output logic      [`PFP_ADC_W-1:0]           adc_res_data
);

  // =====================================================================
  // Elaboration check
  // Port index is five bits wide, so 32 ports is the ceiling
  if ((NPORT < 1) || (NPORT > 32))
  begin : g_bad_nport
    $error("pfp_top: NPORT must lie between 1 and 32");
  end

  // =====================================================================
  // Declarations
  pfp_cfg_t                  cfg_ff [NPORT];
  pfp_cfg_t                  nxt_cfg [NPORT];
  logic [`PFP_REG_W-1:0]     rdata_ff;
  logic [`PFP_REG_W-1:0]     nxt_rdata;
  logic                      rvalid_ff;
  logic                      nxt_rvalid;

  logic [`PFP_MODE_W-1:0]    mode [NPORT];
  logic [NPORT-1:0]          is_adc;
  logic [NPORT-1:0]          is_dac;
  logic [NPORT-1:0]          is_pair;
  pfp_range_t                in_rng [NPORT];
  pfp_range_t                out_rng [NPORT];
  logic [NPORT-1:0]          rng_bad;

  logic [NPORT-1:0]          pv_ff;
  logic [NPORT-1:0]          nxt_pv;
  logic [NPORT*5-1:0]        pidx_ff;
  logic [NPORT*5-1:0]        nxt_pidx;
  logic [NPORT*8-1:0]        cnt_ff;
  logic [NPORT*8-1:0]        nxt_cnt;
  logic [NPORT*3-1:0]        inr_ff;
  logic [NPORT*3-1:0]        nxt_inr;
  logic [NPORT*3-1:0]        outr_ff;
  logic [NPORT*3-1:0]        nxt_outr;
  logic [NPORT-1:0]          rerr_ff;
  logic [NPORT-1:0]          nxt_rerr;

  logic                      addr_hit;
  logic                      wr_hit;
  logic                      smp_hit;
  logic [2:0]                smp_exp;

  // =====================================================================
  // Mode classes per port
  always_comb
  begin
    for (int i = 0; i < NPORT; i++)
    begin
      mode[i]    = port_mode_flat[i*`PFP_MODE_W +: `PFP_MODE_W];
      is_adc[i]  = pfp_in_class(`PFP_ADC_MODES, mode[i]);
      is_dac[i]  = pfp_in_class(`PFP_DAC_MODES, mode[i]);
      is_pair[i] = pfp_in_class(`PFP_PAIR_MODES, mode[i]);
    end
  end

  // =====================================================================
  // Range decode per port
  for (genvar g = 0; g < NPORT; g++)
  begin : g_rng
    pfp_rng u_rng (
      .range_code (pfp_range(cfg_ff[g])),
      .is_input   (is_adc[g]),
      .is_output  (is_dac[g]),
      .is_analog  (is_adc[g] | is_dac[g]),
      .in_range   (in_rng[g]),
      .out_range  (out_rng[g]),
      .code_bad   (rng_bad[g])
    );
  end

  // =====================================================================
  // Register file access
  always_comb
  begin
    addr_hit   = (32'(reg_addr) < NPORT);
    wr_hit     = reg_wr_en && addr_hit;
    nxt_cfg    = cfg_ff;
    nxt_rdata  = rdata_ff;
    nxt_rvalid = reg_rd_en;
    if (wr_hit)
    begin
      nxt_cfg[reg_addr] = reg_wdata;
    end
    if (reg_rd_en)
    begin
      // Unmapped index answers zero
      nxt_rdata = addr_hit ? cfg_ff[reg_addr] : '0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < NPORT; i++)
      begin
        cfg_ff[i] <= `PFP_CFG_RST;
      end
      rdata_ff  <= '0;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      cfg_ff    <= nxt_cfg;
      rdata_ff  <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  // =====================================================================
  // Per-port decoded settings
  always_comb
  begin
    logic [4:0] ptr;
    logic [2:0] ex;
    ptr      = '0;
    ex       = '0;
    nxt_pv   = '0;
    nxt_pidx = '0;
    nxt_cnt  = '0;
    nxt_inr  = '0;
    nxt_outr = '0;
    nxt_rerr = '0;
    for (int i = 0; i < NPORT; i++)
    begin
      ptr = pfp_partner(cfg_ff[i]);
      ex  = pfp_exp(cfg_ff[i]);
      // Out-of-range partner would address a port that does not exist
      if (is_pair[i] && (ptr <= `PFP_MAX_PORT) && (32'(ptr) < NPORT))
      begin
        nxt_pv[i]          = 1'b1;
        nxt_pidx[i*5 +: 5] = ptr;
      end
      // Shown for every port; used only where the mode is ADC
      nxt_cnt[i*8 +: 8]  = 8'h01 << ex;
      nxt_inr[i*3 +: 3]  = 3'(in_rng[i]);
      nxt_outr[i*3 +: 3] = 3'(out_rng[i]);
      nxt_rerr[i]        = rng_bad[i];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pv_ff   <= '0;
      pidx_ff <= '0;
      cnt_ff  <= '0;
      inr_ff  <= '0;
      outr_ff <= '0;
      rerr_ff <= '0;
    end
    else
    begin
      pv_ff   <= nxt_pv;
      pidx_ff <= nxt_pidx;
      cnt_ff  <= nxt_cnt;
      inr_ff  <= nxt_inr;
      outr_ff <= nxt_outr;
      rerr_ff <= nxt_rerr;
    end
  end

  // =====================================================================
  // Sample averaging
  always_comb
  begin
    smp_hit = (32'(adc_smp_port) < NPORT);
    smp_exp = smp_hit ? pfp_exp(cfg_ff[adc_smp_port]) : 3'h0;
  end

  pfp_avg #(
    .NPORT (NPORT),
    .DW    (`PFP_ADC_W),
    .EXPW  (3)
  ) u_avg (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .adc_en    (is_adc),
    .clr_valid (wr_hit),
    .clr_port  (reg_addr),
    .smp_valid (adc_smp_valid),
    .smp_port  (adc_smp_port),
    .smp_data  (adc_smp_data),
    .smp_exp   (smp_exp),
    .res_valid (adc_res_valid),
    .res_port  (adc_res_port),
    .res_data  (adc_res_data)
  );

  // =====================================================================
  // Outputs
  assign reg_rdata        = rdata_ff;
  assign reg_rvalid       = rvalid_ff;
  assign partner_valid    = pv_ff;
  assign partner_idx_flat = pidx_ff;
  assign avg_count_flat   = cnt_ff;
  assign in_range_flat    = inr_ff;
  assign out_range_flat   = outr_ff;
  assign range_err        = rerr_ff;

endmodule : pfp_top

// ==== test/pfp_props.sv ====
`timescale 1ns/1ps
`include "pfp_cfg.svh"

module pfp_props
#(
  parameter int NPORT = `PFP_NPORT
)
(
  input wire logic               clk_sys,
  input wire logic               rst_b,
  input wire logic               reg_rd_en,
  input wire logic [11:0]        reg_rdata,
  input wire logic               reg_rvalid,
  input wire logic [NPORT*4-1:0] port_mode_flat,
  input wire logic [NPORT-1:0]   partner_valid,
  input wire logic [NPORT*5-1:0] partner_idx_flat,
  input wire logic [NPORT*8-1:0] avg_count_flat,
  input wire logic [NPORT*3-1:0] in_range_flat,
  input wire logic [NPORT*3-1:0] out_range_flat,
  input wire logic               adc_smp_valid,
  input wire logic               adc_res_valid,
  input wire logic [4:0]         adc_res_port,
  input wire logic [11:0]        adc_res_data
);
  // ==========
  // Port 0 stands for all ports
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  rd_answer_a: assert property (reg_rd_en |=> reg_rvalid)
    else $error("read not answered");
  rd_quiet_a: assert property (!reg_rd_en |=> !reg_rvalid && $stable(reg_rdata))
    else $error("read data moved without a read");
  avg_pow_a:
    assert property ($past(rst_b, 2) |-> $onehot(avg_count_flat[7:0]))
    else $error("average count not a power of two");
  pair_lim_a:
    assert property (partner_valid[0] |-> partner_idx_flat[4:0] <= 5'h13
      && $past(port_mode_flat[3:0]) inside {4'h4, 4'h8, 4'hb})
    else $error("partner valid out of place");
  partner_zero_a:
    assert property (!partner_valid[0] |-> partner_idx_flat[4:0] == 5'h00)
    else $error("partner index without pairing");
  in_rng_a:
    assert property (!($past(port_mode_flat[3:0]) inside {[4'h7:4'ha]})
      |-> in_range_flat[2:0] == 3'h0)
    else $error("input range outside input mode");
  out_rng_a:
    assert property (!($past(port_mode_flat[3:0]) inside {4'h1, [4'h3:4'h6], 4'ha})
      |-> out_range_flat[2:0] == 3'h0)
    else $error("output range outside output mode");
  res_cause_a:
    assert property (adc_res_valid |-> $past(adc_smp_valid))
    else $error("result without a sample");
  res_hold_a:
    assert property (!adc_res_valid |-> $stable(adc_res_port) && $stable(adc_res_data))
    else $error("result moved without valid");
endmodule : pfp_props

bind pfp_top pfp_props #(.NPORT(NPORT)) pfp_props_inst (
  .clk_sys(clk_sys),
  .rst_b(rst_b),
  .reg_rd_en(reg_rd_en),
  .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid),
  .port_mode_flat(port_mode_flat),
  .partner_valid(partner_valid),
  .partner_idx_flat(partner_idx_flat),
  .avg_count_flat(avg_count_flat),
  .in_range_flat(in_range_flat),
  .out_range_flat(out_range_flat),
  .adc_smp_valid(adc_smp_valid),
  .adc_res_valid(adc_res_valid),
  .adc_res_port(adc_res_port),
  .adc_res_data(adc_res_data)
);

// ==== test/pfp_host.sv ====
`timescale 1ns/1ps

module pfp_host
(
  input  wire logic        clk_sys,
  output logic             reg_wr_en,
  output logic             reg_rd_en,
  output logic [4:0]       reg_addr,
  output logic [11:0]      reg_wdata,
  input  wire logic [11:0] reg_rdata,
  input  wire logic        reg_rvalid,
  output logic             adc_smp_valid,
  output logic [4:0]       adc_smp_port,
  output logic [11:0]      adc_smp_data
);
  initial
  begin
    {reg_wr_en, reg_rd_en, reg_addr, reg_wdata} = '0;
    {adc_smp_valid, adc_smp_port, adc_smp_data} = '0;
  end

  task automatic wr(input logic [4:0] a, input logic [11:0] dat);
    @(posedge clk_sys);
    reg_wr_en <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= dat;
    @(posedge clk_sys);
    reg_wr_en <= 1'b0;
    // Stale data after release must not look valid
    reg_wdata <= ~dat;
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [11:0] q, output logic ok);
    @(posedge clk_sys);
    reg_rd_en <= 1'b1;
    reg_addr  <= a;
    @(posedge clk_sys);
    reg_rd_en <= 1'b0;
    #1;
    q  = reg_rdata;
    ok = reg_rvalid;
  endtask : rd

  task automatic smp(input logic [4:0] p, input logic [11:0] dat);
    @(posedge clk_sys);
    adc_smp_valid <= 1'b1;
    adc_smp_port  <= p;
    adc_smp_data  <= dat;
  endtask : smp

  task automatic smp_end();
    @(posedge clk_sys);
    adc_smp_valid <= 1'b0;
    adc_smp_data  <= ~adc_smp_data;
  endtask : smp_end
endmodule : pfp_host

// ==== test/port_function_param_decode_bench.sv ====
`timescale 1ns/1ps
`include "pfp_cfg.svh"

module port_function_param_decode_bench;
  localparam int N = `PFP_NPORT;
  logic           clk_sys, rst_b, reg_wr_en, reg_rd_en, reg_rvalid, v;
  logic           adc_smp_valid, adc_res_valid;
  logic [4:0]     reg_addr, adc_smp_port, adc_res_port;
  logic [11:0]    reg_wdata, reg_rdata, adc_smp_data, adc_res_data, d;
  logic [N*4-1:0] port_mode_flat;
  logic [N-1:0]   partner_valid, range_err;
  logic [N*5-1:0] partner_idx_flat;
  logic [N*8-1:0] avg_count_flat;
  logic [N*3-1:0] in_range_flat, out_range_flat;
  int             n_mismatch, cmp_count, n_res, r, m, s, t;
  int             cfg[N] = '{default: 0};
  int             md[N] = '{default: 0};

  pfp_top #(.NPORT(N)) pfp_top_inst (.clk_sys(clk_sys), .rst_b(rst_b),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .port_mode_flat(port_mode_flat), .partner_valid(partner_valid),
    .partner_idx_flat(partner_idx_flat), .avg_count_flat(avg_count_flat),
    .in_range_flat(in_range_flat), .out_range_flat(out_range_flat),
    .range_err(range_err), .adc_smp_valid(adc_smp_valid),
    .adc_smp_port(adc_smp_port), .adc_smp_data(adc_smp_data),
    .adc_res_valid(adc_res_valid), .adc_res_port(adc_res_port),
    .adc_res_data(adc_res_data));

  pfp_host pfp_host_inst (.clk_sys(clk_sys), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .adc_smp_valid(adc_smp_valid),
    .adc_smp_port(adc_smp_port), .adc_smp_data(adc_smp_data));

  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
    if (adc_res_valid === 1'b1) n_res <= n_res + 1;

  task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic check_port(input int i);
    int   e;
    logic pv;
    e  = (cfg[i] >> 8) & 7;
    e  = e > 3 ? 4 : e;
    pv = md[i] inside {4, 8, 11} && (cfg[i] & 31) < 20;
    cmp(12'(partner_valid[i]), 12'(pv));
    cmp(12'(partner_idx_flat[5*i+:5]), pv ? 12'(cfg[i] & 31) : 12'h000);
    cmp(12'(avg_count_flat[8*i+:8]), 12'(1 << ((cfg[i] >> 5) & 7)));
    cmp(12'(in_range_flat[3*i+:3]), md[i] inside {[7:10]} ? 12'(e) : 12'h000);
    cmp(12'(out_range_flat[3*i+:3]), md[i] inside {1, [3:6], 10} ? 12'(e) : 12'h000);
    cmp(12'(range_err[i]), 12'(md[i] inside {1, [3:10]} && e == 0));
    pfp_host_inst.rd(5'(i), d, v);
    cmp(12'(v), 12'h001);
    cmp(d, 12'(cfg[i]));
  endtask : check_port

  initial
  begin
    rst_b = 1'b0;
    port_mode_flat = '0;
    n_mismatch = 0;
    cmp_count = 0;
    n_res = 0;
    void'($urandom(35024));
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    // ==========
    // Reset values, then random configurations
    for (int k = 0; k < 5; k++)
    begin
      for (int i = 0; i < N && k > 0; i++)
      begin
        m = $urandom % 16;
        r = $urandom % 4096;
        // Port 0 paired once, so the pairing checks see a live case
        if (i == 0 && k == 1)
        begin
          m = 8;
          r = r & 12'hfef;
        end
        if (m inside {1, [3:10]} && ((r >> 8) & 7) == 0) r = r | 12'h100;
        md[i] = m;
        cfg[i] = r;
        port_mode_flat[4*i+:4] <= 4'(m);
        pfp_host_inst.wr(5'(i), 12'(r));
      end
      // Out-of-range index must leave every register alone
      if (k > 0) pfp_host_inst.wr(5'(N + 2 * k + 3), 12'hfff);
      repeat (3) @(posedge clk_sys);
      #1;
      for (int i = 0; i < N; i++) check_port(i);
      pfp_host_inst.rd(5'(N + k), d, v);
      cmp(12'(v), 12'h001);
      cmp(d, 12'h000);
    end
    // ==========
    // Reset in mid-run: registers back to zero, modes kept, so analog ports flag
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    cfg = '{default: 0};
    repeat (3) @(posedge clk_sys);
    #1;
    for (int i = 0; i < N; i++) check_port(i);
    // ==========
    // Averaging on port 2, every exponent
    @(posedge clk_sys);
    port_mode_flat[23:20] <= 4'h0;
    port_mode_flat[11:8] <= 4'h7;
    for (int n = 0; n < 8; n++)
    begin
      pfp_host_inst.wr(5'd2, 12'(n << 5) | 12'h100);
      s = 0;
      n_res = 0;
      for (int k = 0; k < (1 << n); k++)
      begin
        t = $urandom % 4096;
        s += t;
        pfp_host_inst.smp(5'd2, 12'(t));
        if (k == 0) pfp_host_inst.smp(5'd5, 12'hfff);
      end
      pfp_host_inst.smp(5'd25, 12'hfff);
      pfp_host_inst.smp_end();
      repeat (2) @(posedge clk_sys);
      #1;
      cmp(12'(n_res), 12'h001);
      cmp(12'(adc_res_port), 12'h002);
      cmp(adc_res_data, 12'(s >> n));
    end
    tally_and_finish();
  end
endmodule : port_function_param_decode_bench
